// *** pfc_pkg.sv ***
// pin-function control package: register map, field masks, modes, pin function codes
// assumes a 32-bit apb slave with 8-bit byte addresses
package pfc_pkg;

  localparam int unsigned PFC_AW = 8;
  localparam int unsigned PFC_DW = 32;
  localparam int unsigned PFC_RW = 16;
  localparam int unsigned PFC_PD_PINS = 12;
  localparam int unsigned PFC_PE_PINS = 16;

  // byte offsets
  localparam logic [7:0] PFC_OFF_PD_LOW = 8'h00;
  localparam logic [7:0] PFC_OFF_PE_DIR = 8'h04;
  localparam logic [7:0] PFC_OFF_PE_UP = 8'h08;
  localparam logic [7:0] PFC_OFF_PE_LO = 8'h0C;
  localparam logic [7:0] PFC_OFF_STAT_D = 8'h10;
  localparam logic [7:0] PFC_OFF_STAT_E = 8'h14;

  // reset values
  localparam logic [15:0] PFC_RST_PD_LOW = 16'h0000;
  localparam logic [15:0] PFC_RST_PE_DIR = 16'h0000;
  localparam logic [15:0] PFC_RST_PE_UP = 16'h0000;
  localparam logic [15:0] PFC_RST_PE_LO = 16'h0000;

  // writable bits; the rest read as zero
  localparam logic [15:0] PFC_WMASK_PE_UP = 16'hFD55;
  localparam logic [15:0] PFC_WMASK_PE_LO = 16'h55FF;

  // port e pins with a two-bit select field
  localparam logic [15:0] PFC_PE_WIDE = 16'hE00F;
  // port e pins whose strobe or dma-ack choice is dropped in single-chip mode
  localparam logic [15:0] PFC_PE_ALT_KILL = 16'hC00F;

  // status field positions
  localparam int unsigned PFC_STAT_MODE_LSB = 12;

  typedef enum logic [1:0] {
    PFC_EXT_ROM_OFF,
    PFC_EXT_ROM_ON,
    PFC_SINGLE_CHIP
  } pfc_mode_t;

  typedef enum logic [1:0] {
    PFC_FN_GPIO,
    PFC_FN_TIMER,
    PFC_FN_ALT
  } pfc_func_t;

  typedef struct packed {
    pfc_func_t func;
    logic dir_eff;
    logic oe;
  } pfc_pin_ctl_t;

endpackage

// *** pfc_pin_dec.sv ***
// one port e pin: decodes its select field and direction bit
// ignores code bit 1 for single-bit fields
`timescale 1ns/1ps
module pfc_pin_dec #(
  parameter bit WIDE = 1'b0,
  parameter bit ALT_KILL = 1'b0
) (
  input wire logic [1:0] code,
  input wire logic single_chip,
  input wire logic dir,
  output pfc_pkg::pfc_pin_ctl_t ctl
);
  import pfc_pkg::*;

  wire [1:0] sel = WIDE ? code : {1'b0, code[0]};
  wire alt_dropped = ALT_KILL && single_chip;
  wire is_gpio = (sel == 2'h0) || (sel[1] && alt_dropped);
  wire is_timer = (sel == 2'h1);
  wire eff = is_gpio || is_timer;

  assign ctl.func = is_gpio ? PFC_FN_GPIO : (is_timer ? PFC_FN_TIMER : PFC_FN_ALT);
  assign ctl.dir_eff = eff;
  assign ctl.oe = eff && dir;

endmodule // pfc_pin_dec

// *** pfc_ctrl.sv ***
// pin-function controller for the low port d pins and all of port e
// assumes presetn is the external power-on reset; other resets never reach it
//
// How it works
// R1: low port d mode 0 gives general i/o
// R2: low port d mode 1 gives data bus
// R3: rom disabled forces data bus always
// R4: single-chip forces general i/o always
// R5: 16-bit read/write port e direction register
// R6: direction used only for gpio or timer
// R7: other functions ignore the direction bit
// R8: effective direction 1 makes an output
// R9: effective direction 0 makes an input
// R10: direction register clears on power-on reset
// R11: direction survives every other reset kind
// R12: two 16-bit port e select registers
// R13: first select register drives upper pins
// R14: second select register drives lower pins
// R15: mode may drop strobe and dma-ack choices
// R16: select registers clear only on power-on
// R17: port d select honoured in rom-on mode
// R18: reserved select bits read zero
`timescale 1ns/1ps
module pfc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pfc_pkg::PFC_AW-1:0] paddr,
  input wire logic [pfc_pkg::PFC_DW-1:0] pwdata,
  output logic [pfc_pkg::PFC_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input pfc_pkg::pfc_mode_t op_mode,
  output logic [pfc_pkg::PFC_PD_PINS-1:0] port_d_bus_sel,
  output pfc_pkg::pfc_pin_ctl_t [pfc_pkg::PFC_PE_PINS-1:0] port_e_ctl
);
  import pfc_pkg::*;

  logic [PFC_RW-1:0] port_d_low_func_sel_r;
  logic [PFC_RW-1:0] port_e_direction_r;
  logic [PFC_RW-1:0] port_e_func_sel_upper_r;
  logic [PFC_RW-1:0] port_e_func_sel_lower_r;
  logic [PFC_DW-1:0] prdata_r;
  logic [PFC_DW-1:0] prdata_nxt;

  // bus decode
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_pd = (paddr == PFC_OFF_PD_LOW);
  wire hit_dir = (paddr == PFC_OFF_PE_DIR);
  wire hit_up = (paddr == PFC_OFF_PE_UP);
  wire hit_lo = (paddr == PFC_OFF_PE_LO);
  wire hit_sd = (paddr == PFC_OFF_STAT_D);
  wire hit_se = (paddr == PFC_OFF_STAT_E);
  wire mapped = hit_pd || hit_dir || hit_up || hit_lo || hit_sd || hit_se;
  wire wr = access && pwrite && mapped;
  wire wr_pd = wr && hit_pd;
  wire wr_dir = wr && hit_dir;
  wire wr_up = wr && hit_up;
  wire wr_lo = wr && hit_lo;
  wire [PFC_RW-1:0] wdata16 = pwdata[PFC_RW-1:0];

  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = prdata_r;

  // mode decode
  wire rom_off = (op_mode == PFC_EXT_ROM_OFF);
  wire rom_on = (op_mode == PFC_EXT_ROM_ON);
  wire single_chip = (op_mode == PFC_SINGLE_CHIP);

  // port d low pins
  wire [PFC_PD_PINS-1:0] pd_mode = port_d_low_func_sel_r[PFC_PD_PINS-1:0];
  wire [PFC_PD_PINS-1:0] pd_all = {PFC_PD_PINS{1'b1}};
  wire [PFC_PD_PINS-1:0] pd_none = {PFC_PD_PINS{1'b0}};
  wire [PFC_PD_PINS-1:0] pd_sel_rom_on = pd_mode; // R1 R2 R17
  wire [PFC_PD_PINS-1:0] pd_sel_mode = rom_off ? pd_all : pd_none; // R3 R4

  assign port_d_bus_sel = rom_on ? pd_sel_rom_on : pd_sel_mode; // R17

  // port e: upper register holds pins 15..8, lower holds pins 7..0
  wire [2*PFC_RW-1:0] pe_sel_all = {port_e_func_sel_upper_r, port_e_func_sel_lower_r}; // R13 R14

  genvar gi;
  generate
    for (gi = 0; gi < PFC_PE_PINS; gi++) begin : g_pe
      pfc_pin_dec #(
        .WIDE(PFC_PE_WIDE[gi]),
        .ALT_KILL(PFC_PE_ALT_KILL[gi])
      ) u_dec (
        .code(pe_sel_all[2*gi +: 2]),
        .single_chip(single_chip), // R15
        .dir(port_e_direction_r[gi]), // R6 R7 R8 R9
        .ctl(port_e_ctl[gi])
      );
    end
  endgenerate

  // status views
  logic [PFC_RW-1:0] pe_oe_vec;
  always_comb begin
    pe_oe_vec = '0;
    for (int i = 0; i < PFC_PE_PINS; i++) begin
      pe_oe_vec[i] = port_e_ctl[i].oe;
    end
  end

  wire [PFC_RW-1:0] stat_d = {2'h0, op_mode, 12'(port_d_bus_sel)};
  wire [PFC_RW-1:0] stat_e = pe_oe_vec;

  // read mux, captured in the setup cycle
  wire [PFC_RW-1:0] rd_pd = hit_pd ? port_d_low_func_sel_r : 16'h0000;
  wire [PFC_RW-1:0] rd_dir = hit_dir ? port_e_direction_r : 16'h0000;
  wire [PFC_RW-1:0] rd_up = hit_up ? port_e_func_sel_upper_r : 16'h0000;
  wire [PFC_RW-1:0] rd_lo = hit_lo ? port_e_func_sel_lower_r : 16'h0000;
  wire [PFC_RW-1:0] rd_sd = hit_sd ? stat_d : 16'h0000;
  wire [PFC_RW-1:0] rd_se = hit_se ? stat_e : 16'h0000;
  wire [PFC_RW-1:0] rd16 = rd_pd | rd_dir | rd_up | rd_lo | rd_sd | rd_se;

  assign prdata_nxt = setup ? {16'h0000, rd16} : prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_d_low_func_sel_r <= PFC_RST_PD_LOW;
    end else if (wr_pd) begin
      port_d_low_func_sel_r <= wdata16;
    end
  end

  // only the power-on reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_e_direction_r <= PFC_RST_PE_DIR; // R10 R11
    end else if (wr_dir) begin
      port_e_direction_r <= wdata16; // R5
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_e_func_sel_upper_r <= PFC_RST_PE_UP; // R16
    end else if (wr_up) begin
      port_e_func_sel_upper_r <= wdata16 & PFC_WMASK_PE_UP; // R12 R18
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_e_func_sel_lower_r <= PFC_RST_PE_LO; // R16
    end else if (wr_lo) begin
      port_e_func_sel_lower_r <= wdata16 & PFC_WMASK_PE_LO; // R12 R18
    end
  end

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire [PFC_PD_PINS-1:0] pd_mode_off = ~pd_mode;

  property p_pd_gpio;
    rom_on |-> ((port_d_bus_sel & pd_mode_off) == pd_none);
  endproperty
  a_pd_gpio: assert property (p_pd_gpio) else $error("port d bus without mode bit"); // R1

  property p_pd_bus;
    rom_on |-> (port_d_bus_sel == pd_mode);
  endproperty
  a_pd_bus: assert property (p_pd_bus) else $error("port d mode bit not honoured"); // R2

  property p_pd_rom_off;
    rom_off |-> (port_d_bus_sel == pd_all);
  endproperty
  a_pd_rom_off: assert property (p_pd_rom_off) else $error("rom-off pin not on bus"); // R3

  property p_pd_single;
    single_chip |-> (port_d_bus_sel == pd_none);
  endproperty
  a_pd_single: assert property (p_pd_single) else $error("single-chip pin on bus"); // R4

  sequence s_dir_quiet;
    !wr_dir;
  endsequence

  property p_dir_store;
    logic [15:0] v;
    (wr_dir, v = wdata16) |=> (port_e_direction_r == v);
  endproperty
  a_dir_store: assert property (p_dir_store) else $error("direction write lost"); // R5

  property p_dir_hold;
    s_dir_quiet |=> (port_e_direction_r == $past(port_e_direction_r));
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction changed unwritten"); // R11

  property p_oe_out;
    (port_e_ctl[0].dir_eff && port_e_direction_r[0]) |-> port_e_ctl[0].oe;
  endproperty
  a_oe_out: assert property (p_oe_out) else $error("effective 1 not output"); // R8

  property p_oe_in;
    !port_e_direction_r[15] |-> !port_e_ctl[15].oe;
  endproperty
  a_oe_in: assert property (p_oe_in) else $error("direction 0 drove pin"); // R9

  property p_alt_no_oe;
    (port_e_ctl[13].func == PFC_FN_ALT) |-> (!port_e_ctl[13].oe && !port_e_ctl[13].dir_eff);
  endproperty
  a_alt_no_oe: assert property (p_alt_no_oe) else $error("direction used on alt pin"); // R7

  property p_dir_eff;
    (port_e_ctl[8].func != PFC_FN_ALT) |-> port_e_ctl[8].dir_eff;
  endproperty
  a_dir_eff: assert property (p_dir_eff) else $error("gpio/timer ignores direction"); // R6

  property p_kill_alt;
    single_chip |-> (port_e_ctl[15].func != PFC_FN_ALT && port_e_ctl[14].func != PFC_FN_ALT);
  endproperty
  a_kill_alt: assert property (p_kill_alt) else $error("dropped choice still active"); // R15

  property p_up_timer;
    (wr_up && wdata16[15:14] == 2'h1) |=> (port_e_ctl[15].func == PFC_FN_TIMER);
  endproperty
  a_up_timer: assert property (p_up_timer) else $error("upper select misrouted"); // R13

  property p_lo_timer;
    (wr_lo && wdata16[14] && (wdata16[1:0] == 2'h0)) |=>
      (port_e_ctl[7].func == PFC_FN_TIMER) && (port_e_ctl[0].func == PFC_FN_GPIO);
  endproperty
  a_lo_timer: assert property (p_lo_timer) else $error("lower select misrouted"); // R14

  property p_resv_zero;
    ((port_e_func_sel_upper_r & ~PFC_WMASK_PE_UP) == 16'h0000) &&
      ((port_e_func_sel_lower_r & ~PFC_WMASK_PE_LO) == 16'h0000);
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved select bit set"); // R18

  property p_por_clear;
    $rose(presetn) |-> (port_e_direction_r == PFC_RST_PE_DIR) &&
      (port_e_func_sel_upper_r == PFC_RST_PE_UP) && (port_e_func_sel_lower_r == PFC_RST_PE_LO);
  endproperty
  a_por_clear: assert property (@(posedge pclk) p_por_clear) else $error("not clear after reset"); // R10 R16

  property p_rd_dir;
    (setup && !pwrite && hit_dir) |=> (prdata == {16'h0000, $past(port_e_direction_r)});
  endproperty
  a_rd_dir: assert property (p_rd_dir) else $error("direction readback wrong"); // R5

  // leaving single-chip mode for rom-on mode must hand the pins straight back to the register
  sequence s_leave_single;
    single_chip ##1 rom_on;
  endsequence

  property p_pd_resume;
    s_leave_single |-> (port_d_bus_sel == pd_mode);
  endproperty
  a_pd_resume: assert property (p_pd_resume) else $error("port d select not restored"); // R17

  property p_pd_store;
    logic [15:0] v;
    (wr_pd, v = wdata16) |=> (port_d_low_func_sel_r == v);
  endproperty
  a_pd_store: assert property (p_pd_store) else $error("port d write lost"); // R17

  property p_pd_hold;
    !wr_pd |=> $stable(port_d_low_func_sel_r);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("port d select changed unwritten"); // R17

  property p_up_store;
    logic [15:0] v;
    (wr_up, v = wdata16) |=> (port_e_func_sel_upper_r == (v & PFC_WMASK_PE_UP));
  endproperty
  a_up_store: assert property (p_up_store) else $error("upper select write lost"); // R12

  property p_lo_store;
    logic [15:0] v;
    (wr_lo, v = wdata16) |=> (port_e_func_sel_lower_r == (v & PFC_WMASK_PE_LO));
  endproperty
  a_lo_store: assert property (p_lo_store) else $error("lower select write lost"); // R12

  property p_up_hold;
    !wr_up |=> $stable(port_e_func_sel_upper_r);
  endproperty
  a_up_hold: assert property (p_up_hold) else $error("upper select changed unwritten"); // R16

  property p_lo_hold;
    !wr_lo |=> $stable(port_e_func_sel_lower_r);
  endproperty
  a_lo_hold: assert property (p_lo_hold) else $error("lower select changed unwritten"); // R16

  property p_rd_up;
    (setup && !pwrite && hit_up) |=> (prdata == {16'h0000, $past(port_e_func_sel_upper_r)});
  endproperty
  a_rd_up: assert property (p_rd_up) else $error("upper select readback wrong"); // R12

  property p_rd_lo;
    (setup && !pwrite && hit_lo) |=> (prdata == {16'h0000, $past(port_e_func_sel_lower_r)});
  endproperty
  a_rd_lo: assert property (p_rd_lo) else $error("lower select readback wrong"); // R12

  property p_rd_pd;
    (setup && !pwrite && hit_pd) |=> (prdata == {16'h0000, $past(port_d_low_func_sel_r)});
  endproperty
  a_rd_pd: assert property (p_rd_pd) else $error("port d select readback wrong"); // R17

  property p_rd_stat_d;
    (setup && !pwrite && hit_sd) |=> (prdata[11:0] == $past(port_d_bus_sel));
  endproperty
  a_rd_stat_d: assert property (p_rd_stat_d) else $error("port d status readback wrong"); // R3

  property p_bad_no_write;
    (access && !mapped) |=> $stable(port_e_direction_r) && $stable(port_d_low_func_sel_r) &&
      $stable(port_e_func_sel_upper_r) && $stable(port_e_func_sel_lower_r);
  endproperty
  a_bad_no_write: assert property (p_bad_no_write) else $error("unmapped access wrote"); // R5

  property p_alt15_no_oe;
    (port_e_ctl[15].func == PFC_FN_ALT) |-> !port_e_ctl[15].oe;
  endproperty
  a_alt15_no_oe: assert property (p_alt15_no_oe) else $error("alt pin driven by direction"); // R7

  property p_timer_dir;
    (port_e_ctl[4].func == PFC_FN_TIMER) |-> (port_e_ctl[4].oe == port_e_direction_r[4]);
  endproperty
  a_timer_dir: assert property (p_timer_dir) else $error("timer pin ignores direction"); // R6

  property p_gpio_in;
    (port_e_ctl[3].func == PFC_FN_GPIO && !port_e_direction_r[3]) |-> !port_e_ctl[3].oe;
  endproperty
  a_gpio_in: assert property (p_gpio_in) else $error("gpio input pin driven"); // R9

  property p_kill_lo;
    single_chip |-> (port_e_ctl[3].func != PFC_FN_ALT) && (port_e_ctl[0].func != PFC_FN_ALT);
  endproperty
  a_kill_lo: assert property (p_kill_lo) else $error("dropped dma choice still active"); // R15

  // pin 13 keeps its alternate choice in every mode
  property p_pin13_alt;
    port_e_func_sel_upper_r[11] |-> (port_e_ctl[13].func == PFC_FN_ALT);
  endproperty
  a_pin13_alt: assert property (p_pin13_alt) else $error("pin 13 alternate lost"); // R15

endmodule // pfc_ctrl

// *** test_pfc_ctrl.sv ***
// self-checking testbench for the pin-function controller
// assumes pfc_pkg is compiled first; the bench is the apb master
`timescale 1ns/1ps
module test_pfc_ctrl;
  import pfc_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  logic err;
  pfc_mode_t op_mode = PFC_EXT_ROM_ON;
  logic [11:0] port_d_bus_sel;
  pfc_pin_ctl_t [15:0] port_e_ctl;
  int n_fail = 0;
  int check_count = 0;

  pfc_ctrl u_pfc_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .op_mode(op_mode),
    .port_d_bus_sel(port_d_bus_sel),
    .port_e_ctl(port_e_ctl)
  );

  always #20 pclk = ~pclk;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; returns at the edge where pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20) n_fail++;
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    #1;
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, q, exp);
  endtask

  task automatic setm(input pfc_mode_t m);
    @(posedge pclk);
    op_mode <= m;
    #1;
  endtask

  task automatic t_reset;
    rd("pd_low", PFC_OFF_PD_LOW, 32'h0);
    rd("pe_dir", PFC_OFF_PE_DIR, 32'h0);
    rd("pe_up", PFC_OFF_PE_UP, 32'h0);
    rd("pe_lo", PFC_OFF_PE_LO, 32'h0);
    rd("pe_oe", PFC_OFF_STAT_E, 32'h0);
    chk("pd_sel", port_d_bus_sel, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_port_d;
    wr(PFC_OFF_PD_LOW, 32'h0000FA5F);
    rd("pd_low", PFC_OFF_PD_LOW, 32'h0000FA5F);
    chk("pd_sel_on", port_d_bus_sel, 32'hA5F);
    rd("stat_on", PFC_OFF_STAT_D, 32'h00001A5F);
    setm(PFC_EXT_ROM_OFF);
    chk("pd_sel_off", port_d_bus_sel, 32'hFFF);
    rd("stat_off", PFC_OFF_STAT_D, 32'h00000FFF);
    setm(PFC_SINGLE_CHIP);
    chk("pd_sel_sc", port_d_bus_sel, 32'h000);
    rd("stat_sc", PFC_OFF_STAT_D, 32'h00002000);
    setm(PFC_EXT_ROM_ON);
    $display("test port d done");
  endtask

  task automatic t_dir;
    wr(PFC_OFF_PE_DIR, 32'h0000FFFF);
    rd("pe_dir", PFC_OFF_PE_DIR, 32'h0000FFFF);
    rd("pe_oe", PFC_OFF_STAT_E, 32'h0000FFFF);
    wr(PFC_OFF_PE_DIR, 32'h00008001);
    chk("oe1", port_e_ctl[1].oe, 32'h0);
    chk("oe15", port_e_ctl[15].oe, 32'h1);
    $display("test direction done");
  endtask

  task automatic t_sel;
    wr(PFC_OFF_PE_UP, 32'h0000FFFF);
    rd("pe_up", PFC_OFF_PE_UP, 32'h0000FD55);
    wr(PFC_OFF_PE_LO, 32'h0000FFFF);
    rd("pe_lo", PFC_OFF_PE_LO, 32'h000055FF);
    chk("fn12", port_e_ctl[12].func, PFC_FN_TIMER);
    chk("fn15", port_e_ctl[15].func, PFC_FN_ALT);
    chk("fn4", port_e_ctl[4].func, PFC_FN_TIMER);
    chk("fn0", port_e_ctl[0].func, PFC_FN_ALT);
    chk("deff15", port_e_ctl[15].dir_eff, 32'h0);
    wr(PFC_OFF_PE_DIR, 32'h0000FFFF);
    rd("pe_oe", PFC_OFF_STAT_E, 32'h00001FF0);
    setm(PFC_SINGLE_CHIP);
    rd("pe_oe_sc", PFC_OFF_STAT_E, 32'h0000DFFF);
    chk("fn15_sc", port_e_ctl[15].func, PFC_FN_GPIO);
    chk("fn13_sc", port_e_ctl[13].func, PFC_FN_ALT);
    setm(PFC_EXT_ROM_ON);
    $display("test select done");
  endtask

  task automatic t_bad;
    apb(1'b1, 8'h40, 32'h0000FFFF);
    chk("err_w", err, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk("err_r", err, 32'h1);
    chk("rd_bad", q, 32'h0);
    wr(PFC_OFF_STAT_E, 32'h0);
    rd("pe_oe", PFC_OFF_STAT_E, 32'h00001FF0);
    rd("pd_keep", PFC_OFF_PD_LOW, 32'h0000FA5F);
    $display("test unmapped done");
  endtask

  task automatic t_codes;
    wr(PFC_OFF_PE_UP, 32'h00006400);
    wr(PFC_OFF_PE_LO, 32'h00004020);
    chk("fn15_t", port_e_ctl[15].func, PFC_FN_TIMER);
    chk("deff15_t", port_e_ctl[15].dir_eff, 32'h1);
    chk("fn14_a", port_e_ctl[14].func, PFC_FN_ALT);
    chk("fn13_t", port_e_ctl[13].func, PFC_FN_TIMER);
    chk("fn7_t", port_e_ctl[7].func, PFC_FN_TIMER);
    chk("fn2_a", port_e_ctl[2].func, PFC_FN_ALT);
    chk("fn0_g", port_e_ctl[0].func, PFC_FN_GPIO);
    rd("pe_oe_on", PFC_OFF_STAT_E, 32'h0000BFFB);
    setm(PFC_SINGLE_CHIP);
    rd("pe_oe_sc2", PFC_OFF_STAT_E, 32'h0000FFFF);
    chk("fn14_sc", port_e_ctl[14].func, PFC_FN_GPIO);
    setm(PFC_EXT_ROM_ON);
    $display("test select codes done");
  endtask

  task automatic t_por;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("dir_por", PFC_OFF_PE_DIR, 32'h0);
    rd("up_por", PFC_OFF_PE_UP, 32'h0);
    rd("lo_por", PFC_OFF_PE_LO, 32'h0);
    $display("test power-on reset done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    n_fail++;
    tally_and_finish;
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_port_d;
    t_dir;
    t_sel;
    t_bad;
    t_codes;
    t_por;
    tally_and_finish;
  end
endmodule // test_pfc_ctrl
